//--- rtl/cmr_regs.svh
// Constants for the CPU mode and architectural register block.
`ifndef CMR_REGS_SVH
`define CMR_REGS_SVH
`define CMR_PAGE_BASE_RST 8'h00
`define CMR_IRQ_PAGE_RST 16'h0000
`define CMR_INDEX_RST 24'h000000
`define CMR_PC_RST 24'h000000
`define CMR_SP_RST 24'h000000
`define CMR_REFRESH_RST 8'h00
`define CMR_REFRESH_LOW_W 7
`define CMR_SHORT_BYTES 2'h2
`define CMR_LONG_BYTES 2'h3
`endif

//--- rtl/cmr_pkg.sv
// Types for the CPU mode and architectural register block.
package cmr_pkg;
  // Working register selector for the multibyte pairs.
  typedef enum logic [1:0] {
    CMR_PAIR_BC = 2'b00,
    CMR_PAIR_DE = 2'b01,
    CMR_PAIR_HL = 2'b10,
    CMR_PAIR_AF = 2'b11
  } cmr_pair_t;

  typedef enum logic [1:0] {
    CMR_ADDR_PC = 2'b00,
    CMR_ADDR_SP = 2'b01,
    CMR_ADDR_IDX = 2'b10,
    CMR_ADDR_RAW = 2'b11
  } cmr_asel_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] flags;
    logic [23:0] bc;
    logic [23:0] de;
    logic [23:0] hl;
  } cmr_bank_t;

  // Control operations issued by the instruction decoder.
  typedef struct packed {
    logic fetch;
    logic jump;
    logic [23:0] jump_target;
    logic set_long;
    logic clr_long;
    logic set_mixed;
    logic clr_mixed;
    logic unmask_op;
    logic mask_op;
    logic swap_bank_op;
    logic swap_pair_op;
    logic page_wr;
    logic [7:0] page_wdata;
    logic refresh_wr;
    logic irq_page_wr;
    logic [15:0] irq_page_wdata;
    logic push;
    logic pop;
    logic sp_wr;
    logic [23:0] sp_wdata;
  } cmr_ctl_t;

  typedef struct packed {
    logic wr;
    cmr_pair_t pair;
    logic [23:0] wdata;
    logic idx_wr;
    logic idx_sel;
    logic [1:0] idx_lane;
    logic [23:0] idx_wdata;
    logic [7:0] disp;
    cmr_asel_t asel;
    logic [23:0] raw_addr;
  } cmr_dat_t;

  typedef struct packed {
    cmr_bank_t main;
    cmr_bank_t alt;
    logic [23:0] index_x;
    logic [23:0] index_y;
    logic [23:0] pc;
    logic [7:0] refresh;
    logic [15:0] short_stack_ptr;
    logic [23:0] long_stack_ptr;
    logic [15:0] irq_page;
    logic [7:0] page_base;
    logic long_mode_flag;
    logic mixed_mode_flag;
    logic irq_gate_primary;
    logic irq_gate_second;
    logic [23:0] bus_addr;
    logic [1:0] xfer_bytes;
    logic irq_accept;
    logic [7:0] rd_data;
    logic [23:0] pair_rdata;
    logic [23:0] idx_rdata;
    logic [23:0] sp_out;
  } cmr_state_t;
endpackage

//--- rtl/cmr_core_regs.sv
// CPU memory-mode control, address generation and architectural registers.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "cmr_regs.svh"

// Behaviour
// RULE_01 - Long mode flag 0 selects legacy mode
// RULE_02 - Reset clears the long mode flag
// RULE_03 - Legacy address is page base over 16 bits
// RULE_04 - Long mode uses 24-bit linear addresses
// RULE_05 - Page base writable only in long mode
// RULE_06 - Legacy width stays 16 whatever page base
// RULE_07 - Long mode: 24-bit registers, long stack pointer
// RULE_08 - Multibyte transfers: three bytes long, two legacy
// RULE_09 - Main and alternate banks with paired registers
// RULE_10 - Exchange ops swap main and alternate banks
// RULE_11 - Interrupt page supplies upper vector address bits
// RULE_12 - Index plus sign-extended displacement forms address
// RULE_13 - Index high and low bytes individually accessible
// RULE_14 - PC increments; jump target overrides increment
// RULE_15 - Fetch address per mode from PC
// RULE_16 - Refresh low seven bits count fetches
// RULE_17 - Refresh accessed only via accumulator transfers; the port also reads it directly at RA_REFRESH
// RULE_18 - Legacy stack address is page base over SHORT_STACK_PTR
// RULE_19 - Stack is LIFO for push and pop
// RULE_20 - Long mode flag changes only by mode ops
// RULE_21 - Primary gate 0 blocks maskable interrupts
// RULE_22 - Unmask sets both gates, mask clears both
// RULE_23 - Legacy upper byte of pairs is undefined
// RULE_24 - Refresh count wraps modulo 128
module cmr_core_regs
  import cmr_pkg::*;
#(
  parameter int unsigned ADDR_W = 24
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Decoder control and data requests
  input wire cmr_ctl_t ctl_i,
  input wire cmr_dat_t dat_i,
  input wire logic irq_req_i,
  // Software register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Address and mode outputs
  output logic [ADDR_W-1:0] bus_addr_o,
  output logic [1:0] xfer_bytes_o,
  output logic long_mode_flag_o,
  output logic mixed_mode_flag_o,
  output logic irq_gate_primary_o,
  output logic irq_gate_second_o,
  output logic irq_accept_o,
  output logic [15:0] irq_page_o,
  output logic [23:0] pc_o,
  output logic [23:0] stack_ptr_o,
  output logic [7:0] refresh_o,
  output logic [23:0] pair_rdata_o,
  output logic [23:0] idx_rdata_o
);

  // Software register indexes on the plain port.
  localparam logic [3:0] RA_ACC = 4'h0;
  localparam logic [3:0] RA_REFRESH = 4'h1;
  localparam logic [3:0] RA_PAGE = 4'h2;
  localparam logic [3:0] RA_MODE = 4'h3;

  cmr_state_t s_q;
  cmr_state_t s_d;

  // Legacy addresses are page relative; long mode addresses are linear.
  function automatic logic [23:0] map_addr(input logic lng, input logic [7:0] pb,
                                           input logic [23:0] a);
    map_addr = lng ? a : {pb, a[15:0]}; // [RULE_01] [RULE_03] [RULE_04] [RULE_06]
  endfunction

  function automatic logic [23:0] get_pair(input cmr_bank_t b, input cmr_pair_t p);
    case (p)
      CMR_PAIR_BC: get_pair = b.bc;
      CMR_PAIR_DE: get_pair = b.de;
      CMR_PAIR_HL: get_pair = b.hl;
      default: get_pair = {8'h00, b.acc, b.flags};
    endcase
  endfunction

  logic [23:0] sp_cur;
  logic [23:0] idx_base;
  logic [23:0] idx_eff;
  logic [23:0] new_idx;

  always_comb begin
    s_d = s_q;
    sp_cur = s_q.long_mode_flag ? s_q.long_stack_ptr
                                : {8'h00, s_q.short_stack_ptr}; // [RULE_07]
    idx_base = dat_i.idx_sel ? s_q.index_y : s_q.index_x;
    idx_eff = idx_base + {{16{dat_i.disp[7]}}, dat_i.disp}; // [RULE_12]
    new_idx = idx_base;

    // Program counter: jump wins over the fetch increment.
    if (ctl_i.jump) begin
      s_d.pc = ctl_i.jump_target; // [RULE_14]
    end else if (ctl_i.fetch) begin
      s_d.pc = s_q.pc + 24'h000001; // [RULE_14]
    end
    if (!s_q.long_mode_flag) begin
      s_d.pc[23:16] = 8'h00; // [RULE_15] [RULE_23]
    end

    // Refresh counter keeps bit 7 and wraps the low field.
    if (ctl_i.fetch) begin
      s_d.refresh[6:0] = s_q.refresh[6:0] + 7'h01; // [RULE_16] [RULE_24]
    end
    if (ctl_i.refresh_wr) begin
      s_d.refresh = s_q.main.acc; // [RULE_17]
    end
    // The port may not load the refresh count; only the accumulator transfer can.

    // Page base is frozen in legacy mode to avoid accidental page switches.
    if (s_q.long_mode_flag) begin
      if (ctl_i.page_wr) begin
        s_d.page_base = ctl_i.page_wdata; // [RULE_05]
      end else if (reg_wr_i && reg_addr_i == RA_PAGE) begin
        s_d.page_base = reg_wdata_i; // [RULE_05]
      end
    end

    // Mode flag has no direct software write path.
    if (ctl_i.set_long) begin
      s_d.long_mode_flag = 1'b1; // [RULE_20]
    end else if (ctl_i.clr_long) begin
      s_d.long_mode_flag = 1'b0; // [RULE_20]
    end
    if (ctl_i.set_mixed) begin
      s_d.mixed_mode_flag = 1'b1;
    end else if (ctl_i.clr_mixed) begin
      s_d.mixed_mode_flag = 1'b0;
    end

    if (ctl_i.unmask_op) begin
      s_d.irq_gate_primary = 1'b1; // [RULE_22]
      s_d.irq_gate_second = 1'b1; // [RULE_22]
    end else if (ctl_i.mask_op) begin
      s_d.irq_gate_primary = 1'b0; // [RULE_22]
      s_d.irq_gate_second = 1'b0; // [RULE_22]
    end
    s_d.irq_accept = irq_req_i && s_q.irq_gate_primary; // [RULE_21]

    if (ctl_i.irq_page_wr) begin
      s_d.irq_page = ctl_i.irq_page_wdata; // [RULE_11]
    end

    // Stack pointer per mode; push predecrements, pop postincrements.
    if (ctl_i.sp_wr) begin
      if (s_q.long_mode_flag) begin
        s_d.long_stack_ptr = ctl_i.sp_wdata; // [RULE_07]
      end else begin
        s_d.short_stack_ptr = ctl_i.sp_wdata[15:0];
      end
    end else if (ctl_i.push ^ ctl_i.pop) begin
      if (s_q.long_mode_flag) begin
        s_d.long_stack_ptr = ctl_i.push ? s_q.long_stack_ptr - 24'h000003
                                        : s_q.long_stack_ptr + 24'h000003; // [RULE_19]
      end else begin
        s_d.short_stack_ptr = ctl_i.push ? s_q.short_stack_ptr - 16'h0002
                                         : s_q.short_stack_ptr + 16'h0002; // [RULE_19]
      end
    end

    // Registered view of the active stack pointer, so the output needs no mux.
    s_d.sp_out = s_d.long_mode_flag ? s_d.long_stack_ptr
                                    : {8'h00, s_d.short_stack_ptr}; // [RULE_07]

    // Working bank writes; legacy writes leave the upper byte undefined (cleared).
    if (dat_i.wr) begin // [RULE_09]
      case (dat_i.pair)
        CMR_PAIR_BC: s_d.main.bc = s_q.long_mode_flag ? dat_i.wdata
                                   : {8'h00, dat_i.wdata[15:0]}; // [RULE_23]
        CMR_PAIR_DE: s_d.main.de = s_q.long_mode_flag ? dat_i.wdata
                                   : {8'h00, dat_i.wdata[15:0]};
        CMR_PAIR_HL: s_d.main.hl = s_q.long_mode_flag ? dat_i.wdata
                                   : {8'h00, dat_i.wdata[15:0]};
        default: begin
          s_d.main.acc = dat_i.wdata[15:8];
          s_d.main.flags = dat_i.wdata[7:0];
        end
      endcase
    end
    if (ctl_i.refresh_wr == 1'b0 && reg_wr_i && reg_addr_i == RA_ACC) begin
      s_d.main.acc = reg_wdata_i;
    end

    // Index writes: lane 1 low byte, lane 2 high byte, else whole word.
    if (dat_i.idx_wr) begin
      case (dat_i.idx_lane)
        2'h1: new_idx = {idx_base[23:8], dat_i.idx_wdata[7:0]}; // [RULE_13]
        2'h2: new_idx = {idx_base[23:16], dat_i.idx_wdata[7:0], idx_base[7:0]}; // [RULE_13]
        default: new_idx = s_q.long_mode_flag ? dat_i.idx_wdata
                           : {8'h00, dat_i.idx_wdata[15:0]};
      endcase
      if (dat_i.idx_sel) begin
        s_d.index_y = new_idx;
      end else begin
        s_d.index_x = new_idx;
      end
    end

    // Exchanges act on the state before this cycle's writes.
    if (ctl_i.swap_bank_op) begin
      s_d.main.bc = s_q.alt.bc; // [RULE_10]
      s_d.main.de = s_q.alt.de;
      s_d.main.hl = s_q.alt.hl;
      s_d.alt.bc = s_q.main.bc;
      s_d.alt.de = s_q.main.de;
      s_d.alt.hl = s_q.main.hl;
    end
    if (ctl_i.swap_pair_op) begin
      s_d.main.acc = s_q.alt.acc; // [RULE_10]
      s_d.main.flags = s_q.alt.flags;
      s_d.alt.acc = s_q.main.acc;
      s_d.alt.flags = s_q.main.flags;
    end

    // Address generation.
    case (dat_i.asel)
      CMR_ADDR_PC: s_d.bus_addr = map_addr(s_q.long_mode_flag, s_q.page_base, s_q.pc); // [RULE_15]
      CMR_ADDR_SP: s_d.bus_addr = map_addr(s_q.long_mode_flag, s_q.page_base, sp_cur); // [RULE_18]
      CMR_ADDR_IDX: s_d.bus_addr = map_addr(s_q.long_mode_flag, s_q.page_base, idx_eff);
      default: s_d.bus_addr = map_addr(s_q.long_mode_flag, s_q.page_base, dat_i.raw_addr);
    endcase
    s_d.xfer_bytes = s_q.long_mode_flag ? `CMR_LONG_BYTES : `CMR_SHORT_BYTES; // [RULE_08]

    s_d.pair_rdata = get_pair(s_q.main, dat_i.pair);
    s_d.idx_rdata = idx_base;

    // Read data stands only in the cycle after the read strobe.
    s_d.rd_data = 8'h00;
    if (reg_rd_i) begin
      if (reg_addr_i == RA_ACC) begin
        s_d.rd_data = s_q.main.acc;
      end else if (reg_addr_i == RA_REFRESH) begin
        s_d.rd_data = s_q.refresh; // [RULE_17]
      end else if (reg_addr_i == RA_PAGE) begin
        s_d.rd_data = s_q.page_base;
      end else if (reg_addr_i == RA_MODE) begin
        s_d.rd_data = {4'h0, s_q.irq_gate_second, s_q.irq_gate_primary,
                       s_q.mixed_mode_flag, s_q.long_mode_flag};
      end else begin
        s_d.rd_data = 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
      s_q.long_mode_flag <= 1'b0; // [RULE_02]
      s_q.page_base <= `CMR_PAGE_BASE_RST;
      s_q.irq_page <= `CMR_IRQ_PAGE_RST;
      s_q.index_x <= `CMR_INDEX_RST;
      s_q.index_y <= `CMR_INDEX_RST;
      s_q.pc <= `CMR_PC_RST;
      s_q.refresh <= `CMR_REFRESH_RST;
      s_q.xfer_bytes <= `CMR_SHORT_BYTES;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rd_data;
  assign bus_addr_o = s_q.bus_addr[ADDR_W-1:0];
  assign xfer_bytes_o = s_q.xfer_bytes;
  assign long_mode_flag_o = s_q.long_mode_flag;
  assign mixed_mode_flag_o = s_q.mixed_mode_flag;
  assign irq_gate_primary_o = s_q.irq_gate_primary;
  assign irq_gate_second_o = s_q.irq_gate_second;
  assign irq_accept_o = s_q.irq_accept;
  assign irq_page_o = s_q.irq_page;
  assign pc_o = s_q.pc;
  assign stack_ptr_o = s_q.sp_out;
  assign refresh_o = s_q.refresh;
  assign pair_rdata_o = s_q.pair_rdata;
  assign idx_rdata_o = s_q.idx_rdata;

  // Each check looks one edge after its cause, against the state sampled at the cause.
  a_reset_legacy: assert property (@(posedge ref_clk_i) // [RULE_02]
    !rst_b_i |=> !s_q.long_mode_flag)
    else $error("long mode flag set after reset");
  a_legacy_addr_page: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_03]
    (!s_q.long_mode_flag && dat_i.asel == CMR_ADDR_PC) |=> (s_q.bus_addr ==
      {$past(s_q.page_base), $past(s_q.pc[15:0])}))
    else $error("legacy fetch address not page based");
  a_long_addr_linear: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_04]
    (s_q.long_mode_flag && dat_i.asel == CMR_ADDR_PC) |=> (s_q.bus_addr == $past(s_q.pc)))
    else $error("long fetch address not linear");
  a_page_frozen: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_05]
    !s_q.long_mode_flag |=> $stable(s_q.page_base))
    else $error("page base changed in legacy mode");
  a_xfer_count: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_08]
    ##1 (s_q.xfer_bytes == ($past(s_q.long_mode_flag) ? 2'h3 : 2'h2)))
    else $error("transfer byte count wrong for mode");
  a_jump_wins: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_14]
    (ctl_i.jump && s_q.long_mode_flag) |=> (s_q.pc == $past(ctl_i.jump_target)))
    else $error("jump target not loaded");
  a_refresh_step: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_16]
    (ctl_i.fetch && !ctl_i.refresh_wr && !(reg_wr_i && reg_addr_i == RA_REFRESH))
    |=> (s_q.refresh == {$past(s_q.refresh[7]), $past(s_q.refresh[6:0]) + 7'h01}))
    else $error("refresh count step wrong");
  a_mode_steady: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_20]
    (!ctl_i.set_long && !ctl_i.clr_long) |=> $stable(s_q.long_mode_flag))
    else $error("mode flag changed without mode op");
  a_irq_blocked: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_21]
    !s_q.irq_gate_primary |=> !s_q.irq_accept)
    else $error("interrupt accepted while gated");
  a_gates_pair: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_22]
    ctl_i.unmask_op |=> (s_q.irq_gate_primary && s_q.irq_gate_second) ##0 (1'b1))
    else $error("unmask did not set both gates");
  a_bank_swap: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_10]
    (ctl_i.swap_bank_op && !dat_i.wr) |=> (s_q.main.bc == $past(s_q.alt.bc) &&
      s_q.alt.bc == $past(s_q.main.bc)))
    else $error("bank exchange failed");
  a_legacy_pair_upper: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_23]
    (!s_q.long_mode_flag && dat_i.wr && dat_i.pair == CMR_PAIR_BC && !ctl_i.swap_bank_op)
    |=> (s_q.main.bc[23:16] == 8'h00))
    else $error("legacy pair write widened");
  a_long_push: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_07]
    (s_q.long_mode_flag && ctl_i.push && !ctl_i.pop && !ctl_i.sp_wr)
    |=> (s_q.long_stack_ptr == $past(s_q.long_stack_ptr) - 24'h000003))
    else $error("long stack push step wrong");
  a_pair_swap: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_10]
    ctl_i.swap_pair_op |=> (s_q.main.acc == $past(s_q.alt.acc) &&
      s_q.alt.acc == $past(s_q.main.acc)))
    else $error("accumulator exchange failed");
  a_irq_page_load: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_11]
    ctl_i.irq_page_wr |=> (s_q.irq_page == $past(ctl_i.irq_page_wdata)))
    else $error("interrupt page not loaded");
  a_idx_disp: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_12]
    (!s_q.long_mode_flag && dat_i.asel == CMR_ADDR_IDX) |=> (s_q.bus_addr ==
      {$past(s_q.page_base), $past(dat_i.idx_sel ? s_q.index_y[15:0] : s_q.index_x[15:0])
        + {{8{$past(dat_i.disp[7])}}, $past(dat_i.disp)}}))
    else $error("indexed address wrong");
  a_idx_low: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_13]
    (dat_i.idx_wr && dat_i.idx_lane == 2'h1 && !dat_i.idx_sel) |=>
      (s_q.index_x == {$past(s_q.index_x[23:8]), $past(dat_i.idx_wdata[7:0])}))
    else $error("index low byte write wrong");
  a_idx_high: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_13]
    (dat_i.idx_wr && dat_i.idx_lane == 2'h2 && !dat_i.idx_sel) |=>
      (s_q.index_x == {$past(s_q.index_x[23:16]), $past(dat_i.idx_wdata[7:0]),
        $past(s_q.index_x[7:0])}))
    else $error("index high byte write wrong");
  a_pc_step: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_14]
    (ctl_i.fetch && !ctl_i.jump) |=> (s_q.pc[15:0] == $past(s_q.pc[15:0]) + 16'h0001))
    else $error("program counter step wrong");
  a_pc_upper: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_15]
    !s_q.long_mode_flag |=> (s_q.pc[23:16] == 8'h00))
    else $error("legacy program counter upper byte set");
  a_refresh_msb: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_16]
    !ctl_i.refresh_wr |=> (s_q.refresh[7] == $past(s_q.refresh[7])))
    else $error("refresh top bit changed without write");
  a_legacy_stack: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_18]
    (!s_q.long_mode_flag && dat_i.asel == CMR_ADDR_SP) |=> (s_q.bus_addr ==
      {$past(s_q.page_base), $past(s_q.short_stack_ptr)}))
    else $error("legacy stack address not page based");
  a_short_push: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_19]
    (!s_q.long_mode_flag && ctl_i.push && !ctl_i.pop && !ctl_i.sp_wr)
    |=> (s_q.short_stack_ptr == $past(s_q.short_stack_ptr) - 16'h0002))
    else $error("short stack push step wrong");
  a_short_pop: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_19]
    (!s_q.long_mode_flag && ctl_i.pop && !ctl_i.push && !ctl_i.sp_wr)
    |=> (s_q.short_stack_ptr == $past(s_q.short_stack_ptr) + 16'h0002))
    else $error("short stack pop step wrong");
  a_accept_pass: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_21]
    (irq_req_i && s_q.irq_gate_primary) |=> s_q.irq_accept)
    else $error("open interrupt not accepted");
  a_gates_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE_22]
    (ctl_i.mask_op && !ctl_i.unmask_op) |=> (!s_q.irq_gate_primary && !s_q.irq_gate_second))
    else $error("mask did not clear both gates");

endmodule // cmr_core_regs

//--- testbench/cmr_mem_model.sv
// Behavioural memory standing on the far side of the core's address bus.
`timescale 1ns/1ps
module cmr_mem_model (
  // Clock
  input wire logic clk_i,
  // Address from the core
  input wire logic [23:0] addr_i,
  // Read data out to the bench
  output logic [7:0] rd_data_o
);
  logic [7:0] mem_q [0:255];

  // The page byte is folded into the data so that a wrong page still shows up on the bus.
  always_ff @(posedge clk_i) begin
    rd_data_o <= mem_q[addr_i[7:0]] ^ addr_i[23:16];
  end

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem_q[i] = i[7:0];
    end
  end
endmodule // cmr_mem_model

//--- testbench/cmr_core_regs_tb.sv
// Self-checking bench for the CPU mode, address and register block.
`timescale 1ns/1ps
module cmr_core_regs_tb
  import cmr_pkg::*;
;
  logic ref_clk_i, rst_b_i, irq_req_i, reg_wr_i, reg_rd_i;
  cmr_ctl_t ctl_i, cv;
  cmr_dat_t dat_i, dv;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, refresh_o, mem_rd;
  logic [23:0] bus_addr_o, pc_o, stack_ptr_o, pair_rdata_o, idx_rdata_o;
  logic [1:0] xfer_bytes_o;
  logic long_mode_flag_o, mixed_mode_flag_o, irq_gate_primary_o, irq_gate_second_o;
  logic irq_accept_o;
  logic [15:0] irq_page_o;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;

  cmr_core_regs dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ctl_i(ctl_i), .dat_i(dat_i),
    .irq_req_i(irq_req_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .bus_addr_o(bus_addr_o), .xfer_bytes_o(xfer_bytes_o), .long_mode_flag_o(long_mode_flag_o),
    .mixed_mode_flag_o(mixed_mode_flag_o), .irq_gate_primary_o(irq_gate_primary_o),
    .irq_gate_second_o(irq_gate_second_o), .irq_accept_o(irq_accept_o),
    .irq_page_o(irq_page_o), .pc_o(pc_o), .stack_ptr_o(stack_ptr_o), .refresh_o(refresh_o),
    .pair_rdata_o(pair_rdata_o), .idx_rdata_o(idx_rdata_o));

  cmr_mem_model mem (.clk_i(ref_clk_i), .addr_i(bus_addr_o), .rd_data_o(mem_rd));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // The run is about 150 cycles; anything far beyond means a hang.
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Applies the staged decoder request for one cycle, then lets its results land.
  task automatic go();
    @(posedge ref_clk_i);
    ctl_i <= cv;
    dat_i <= dv;
    @(posedge ref_clk_i);
    ctl_i <= '0;
    dat_i <= '0;
    cv = '0;
    dv = '0;
    #1;
  endtask

  task automatic rwr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rrd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk({16'h0, reg_rdata_o}, {16'h0, exp});
  endtask

  task automatic t_reset();
    chk(long_mode_flag_o, 24'h0);
    chk(xfer_bytes_o, 24'h2);
    chk(pc_o, 24'h0);
    chk(irq_gate_primary_o, 24'h0);
  endtask

  task automatic t_mode();
    rwr(4'h2, 8'hA5);
    rrd(4'h2, 8'h00);
    cv.page_wr = 1'b1;
    cv.page_wdata = 8'h5A;
    go();
    rrd(4'h2, 8'h00);
    cv.set_long = 1'b1;
    go();
    chk(long_mode_flag_o, 24'h1);
    rwr(4'h3, 8'h00);
    rrd(4'h3, 8'h01);
    chk(xfer_bytes_o, 24'h3);
    rwr(4'h2, 8'h37);
    rrd(4'h2, 8'h37);
    dv.asel = CMR_ADDR_RAW;
    dv.raw_addr = 24'h123456;
    go();
    chk(bus_addr_o, 24'h123456);
    cv.clr_long = 1'b1;
    go();
    chk(long_mode_flag_o, 24'h0);
    dv.asel = CMR_ADDR_RAW;
    dv.raw_addr = 24'h123456;
    go();
    chk(bus_addr_o, 24'h373456);
    chk(xfer_bytes_o, 24'h2);
    @(posedge ref_clk_i);
    #1;
    chk({16'h0, mem_rd}, 24'h000061);
  endtask

  task automatic t_pc_refresh();
    cv.jump = 1'b1;
    cv.jump_target = 24'h561234;
    go();
    chk(pc_o, 24'h001234);
    cv.fetch = 1'b1;
    go();
    chk(pc_o, 24'h001235);
    cv.fetch = 1'b1;
    cv.jump = 1'b1;
    cv.jump_target = 24'h000200;
    go();
    chk(pc_o, 24'h000200);
    go();
    chk(bus_addr_o, 24'h370200);
    rwr(4'h0, 8'hFE);
    cv.refresh_wr = 1'b1;
    go();
    cv.fetch = 1'b1;
    go();
    chk(refresh_o, 24'hFF);
    cv.fetch = 1'b1;
    go();
    chk(refresh_o, 24'h80);
    rwr(4'h0, 8'h7F);
    cv.refresh_wr = 1'b1;
    go();
    cv.fetch = 1'b1;
    go();
    chk(refresh_o, 24'h00);
    rwr(4'h0, 8'h5A);
    cv.refresh_wr = 1'b1;
    go();
    rrd(4'h1, 8'h5A);
  endtask

  task automatic t_stack();
    cv.sp_wr = 1'b1;
    cv.sp_wdata = 24'hAB1000;
    go();
    chk(stack_ptr_o, 24'h001000);
    cv.push = 1'b1;
    go();
    chk(stack_ptr_o, 24'h000FFE);
    dv.asel = CMR_ADDR_SP;
    go();
    chk(bus_addr_o, 24'h370FFE);
    cv.pop = 1'b1;
    go();
    chk(stack_ptr_o, 24'h001000);
    cv.set_long = 1'b1;
    go();
    cv.sp_wr = 1'b1;
    cv.sp_wdata = 24'hAB1000;
    go();
    cv.push = 1'b1;
    go();
    chk(stack_ptr_o, 24'hAB0FFD);
    cv.jump = 1'b1;
    cv.jump_target = 24'h561234;
    go();
    chk(pc_o, 24'h561234);
    go();
    chk(bus_addr_o, 24'h561234);
    cv.clr_long = 1'b1;
    go();
    chk(stack_ptr_o, 24'h001000);
  endtask

  task automatic t_index();
    dv.idx_wr = 1'b1;
    dv.idx_wdata = 24'h001000;
    go();
    dv.asel = CMR_ADDR_IDX;
    dv.disp = 8'hF0;
    go();
    chk(bus_addr_o, 24'h370FF0);
    dv.idx_wr = 1'b1;
    dv.idx_sel = 1'b1;
    dv.idx_wdata = 24'h0000FE;
    go();
    dv.asel = CMR_ADDR_IDX;
    dv.idx_sel = 1'b1;
    dv.disp = 8'h7F;
    go();
    chk(bus_addr_o, 24'h37017D);
    dv.idx_wr = 1'b1;
    dv.idx_lane = 2'h1;
    dv.idx_wdata = 24'hABABAB;
    go();
    dv.idx_wr = 1'b1;
    dv.idx_lane = 2'h2;
    dv.idx_wdata = 24'hCDCDCD;
    go();
    go();
    chk(idx_rdata_o, 24'h00CDAB);
  endtask

  task automatic t_banks();
    dv.wr = 1'b1;
    dv.wdata = 24'h001111;
    go();
    go();
    chk(pair_rdata_o, 24'h001111);
    cv.swap_bank_op = 1'b1;
    go();
    go();
    chk(pair_rdata_o, 24'h000000);
    cv.swap_bank_op = 1'b1;
    go();
    go();
    chk(pair_rdata_o, 24'h001111);
    dv.wr = 1'b1;
    dv.pair = CMR_PAIR_AF;
    dv.wdata = 24'h00C33C;
    go();
    rrd(4'h0, 8'hC3);
    cv.swap_pair_op = 1'b1;
    go();
    rrd(4'h0, 8'h00);
  endtask

  task automatic t_irq();
    @(posedge ref_clk_i);
    irq_req_i <= 1'b1;
    go();
    chk(irq_accept_o, 24'h0);
    cv.unmask_op = 1'b1;
    go();
    chk({irq_gate_second_o, irq_gate_primary_o}, 24'h3);
    go();
    chk(irq_accept_o, 24'h1);
    rrd(4'h3, 8'h0C);
    cv.set_mixed = 1'b1;
    go();
    chk(mixed_mode_flag_o, 24'h1);
    rrd(4'h3, 8'h0E);
    cv.clr_mixed = 1'b1;
    go();
    chk(mixed_mode_flag_o, 24'h0);
    cv.mask_op = 1'b1;
    go();
    chk({irq_gate_second_o, irq_gate_primary_o}, 24'h0);
    go();
    chk(irq_accept_o, 24'h0);
    @(posedge ref_clk_i);
    irq_req_i <= 1'b0;
    cv.irq_page_wr = 1'b1;
    cv.irq_page_wdata = 16'hBEEF;
    go();
    chk(irq_page_o, 24'h00BEEF);
    rrd(4'h5, 8'h00);
  endtask

  initial begin
    rst_b_i = 1'b0;
    irq_req_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    ctl_i = '0;
    dat_i = '0;
    cv = '0;
    dv = '0;
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    t_reset();
    t_mode();
    t_pc_refresh();
    t_stack();
    t_index();
    t_banks();
    t_irq();
    test_done();
  end
endmodule // cmr_core_regs_tb
